/* design/kwd_cfg.svh */
// Purpose: Constants for the keyed watchdog timer
// Assumes: Byte addresses on a 32-bit register bus
// Notes:   Definitions only
`ifndef KWD_CFG_SVH
`define KWD_CFG_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define KWD_OFS_OVF_MODE 8'h00
`define KWD_OFS_CLK_MODE 8'h04
`define KWD_OFS_RESTART 8'h08
`define KWD_OFS_OVF_STAT 8'h0C
`define KWD_OFS_IRQ_STAT 8'h10
`define KWD_OFS_IRQ_CLR 8'h14
`define KWD_OFS_IRQ_EN 8'h18

// ****************************************************
// Field positions and keys
// ****************************************************
`define KWD_OM_EN 0
`define KWD_OM_RST 1
`define KWD_OM_IRQ 2
`define KWD_OM_EXT 3
`define KWD_OM_KEY_HI 15
`define KWD_OM_KEY_LO 4
`define KWD_OM_KEY 12'h234
`define KWD_CM_SEL_HI 1
`define KWD_CM_SEL_LO 0
`define KWD_CM_HP_HI 5
`define KWD_CM_HP_LO 2
`define KWD_CM_KEY_HI 15
`define KWD_CM_KEY_LO 7
`define KWD_CM_KEY 9'h06E
`define KWD_RESTART_KEY 16'hC071
`define KWD_PRELOAD_LOW 12'hFFF

// ****************************************************
// Reset values and timing
// ****************************************************
`define KWD_OM_RESET 4'h0
`define KWD_CM_RESET 6'h00
`define KWD_EXT_PULSE_CYC 4'h8
`define KWD_DIV8_BITS 3
`define KWD_DIV32_BITS 5
`define KWD_DIV128_BITS 7
`define KWD_DIV1024_BITS 10
`define KWD_IRQ_EV_OVF 0
`define KWD_IRQ_EV_KEY 1

`endif

/* design/kwd_pkg.sv */
// Purpose: Types for the keyed watchdog timer
// Assumes: Constants come from kwd_cfg.svh
// Notes:   Types only
package kwd_pkg;

  // Bus answer states, one-hot
  typedef enum logic [1:0]
  {
    KWD_BUS_WAIT = 2'b01,
    KWD_BUS_ACK = 2'b10
  } kwd_bus_state_t;

  // Prescaler tap selection
  typedef enum logic [1:0]
  {
    KWD_DIV8 = 2'b00,
    KWD_DIV32 = 2'b01,
    KWD_DIV128 = 2'b10,
    KWD_DIV1024 = 2'b11
  } kwd_clksel_t;

endpackage

/* design/kwd_prescaler.sv */
// Purpose: Master clock prescaler with four tick taps
// Assumes: One clock, synchronous reset
// Notes:   Tick is one cycle wide, registered
`timescale 1ns/1ns
`include "kwd_cfg.svh"
module kwd_prescaler
#(
  parameter int DIV_W = `KWD_DIV1024_BITS
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic clear_in,
  input wire kwd_pkg::kwd_clksel_t sel_in,
  output logic tick_out
);
  import kwd_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic tick_q;
  logic tick_d;
  wire logic [3:0] tap_ones;

  // ****************************************************
  // Tap decode
  // ****************************************************
  // A tap fires when its low bits are all ones
  assign tap_ones[0] = &div_q[`KWD_DIV8_BITS-1:0];
  assign tap_ones[1] = &div_q[`KWD_DIV32_BITS-1:0];
  assign tap_ones[2] = &div_q[`KWD_DIV128_BITS-1:0];
  assign tap_ones[3] = &div_q[`KWD_DIV1024_BITS-1:0];
  assign div_d = clear_in ? '0 : div_q + 1'b1;
  assign tick_d = ~clear_in & tap_ones[sel_in];
  assign tick_out = tick_q;

  // Free-running divider, cleared on restart
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

endmodule // kwd_prescaler

/* design/kwd_watchdog.sv */
// Purpose: Keyed watchdog timer with Avalon-MM register slave
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Keyed writes need byte lanes 0 and 1 enabled
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "kwd_cfg.svh"
// Contract
// - Overflow with reset enable raises the internal reset request.
// - Overflow with interrupt enable emits one interrupt pulse.
// - Overflow with external enable drives overflow pin low 8 cycles.
// - The timing element is a 16-bit down counter.
// - Restart loads ones in bits 0-11, preload field in 12-15.
// - Clock select picks master clock divided by 8, 32, 128, 1024.
// - Mode registers change only with the right key in that write.
// - Overflow mode key is 0x234; key field reads zero.
// - Clock mode key is 0x06E; key field reads zero.
// - Disabled timer makes no overflow outputs; enabled makes each selected one.
// - Writing 0xC071 to restart register restarts; others only set the key-fail interrupt status bit.
// - Overflow flag sets on overflow, clears on restart or reset.
module kwd_watchdog
#(
  parameter int CNT_W = 16,
  parameter int PULSE_W = 4
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic internal_reset_request_out,
  output logic overflow_interrupt_pulse_out,
  output logic overflow_output_n_out,
  output logic irq_out
);
  import kwd_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  kwd_bus_state_t bus_q;
  kwd_bus_state_t bus_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0] omr_q;
  logic [3:0] omr_d;
  logic [5:0] cmr_q;
  logic [5:0] cmr_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic ovf_flag_q;
  logic ovf_flag_d;
  logic rst_req_q;
  logic int_pulse_q;
  logic [PULSE_W-1:0] ext_cnt_q;
  logic [PULSE_W-1:0] ext_cnt_d;
  logic ext_n_q;
  logic [1:0] ist_q;
  logic [1:0] ist_d;
  logic [1:0] ien_q;
  logic [1:0] ien_d;
  logic irq_q;
  wire logic tick;
  wire logic access;
  wire logic wr_acc;
  wire logic rd_acc;
  wire logic lanes_ok;
  wire logic hit_omr;
  wire logic hit_cmr;
  wire logic hit_rst;
  wire logic hit_ost;
  wire logic hit_ist;
  wire logic hit_icl;
  wire logic hit_ien;
  wire logic omr_key_ok;
  wire logic cmr_key_ok;
  wire logic omr_wr;
  wire logic cmr_wr;
  wire logic restart;
  wire logic key_fail;
  wire logic ovf_evt;
  wire logic en;
  wire logic [1:0] ev_vec;
  wire logic [1:0] clr_vec;
  wire logic [CNT_W-1:0] preload;

  // ****************************************************
  // Address decode
  // ****************************************************
  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Request is served in the cycle waitrequest is low
  assign access = (avs_read_in | avs_write_in) & (bus_q == KWD_BUS_ACK);
  assign wr_acc = access & avs_write_in;
  assign rd_acc = (avs_read_in | avs_write_in) & (bus_q == KWD_BUS_WAIT);
  assign lanes_ok = &avs_byteenable_in[1:0];
  assign hit_omr = hit(avs_address_in, `KWD_OFS_OVF_MODE);
  assign hit_cmr = hit(avs_address_in, `KWD_OFS_CLK_MODE);
  assign hit_rst = hit(avs_address_in, `KWD_OFS_RESTART);
  assign hit_ost = hit(avs_address_in, `KWD_OFS_OVF_STAT);
  assign hit_ist = hit(avs_address_in, `KWD_OFS_IRQ_STAT);
  assign hit_icl = hit(avs_address_in, `KWD_OFS_IRQ_CLR);
  assign hit_ien = hit(avs_address_in, `KWD_OFS_IRQ_EN);

  // ****************************************************
  // Keyed write checks
  // ****************************************************
  // Key fields are compared, never stored
  assign omr_key_ok = avs_writedata_in[`KWD_OM_KEY_HI:`KWD_OM_KEY_LO]
    == `KWD_OM_KEY;
  assign cmr_key_ok = avs_writedata_in[`KWD_CM_KEY_HI:`KWD_CM_KEY_LO]
    == `KWD_CM_KEY;
  assign omr_wr = wr_acc & hit_omr & lanes_ok & omr_key_ok;
  assign cmr_wr = wr_acc & hit_cmr & lanes_ok & cmr_key_ok;
  assign restart = wr_acc & hit_rst & lanes_ok
    & (avs_writedata_in[15:0] == `KWD_RESTART_KEY);
  assign key_fail = wr_acc & (hit_omr | hit_cmr | hit_rst)
    & ~(omr_wr | cmr_wr | restart);

  // Mode register next values
  assign omr_d = omr_wr ? avs_writedata_in[`KWD_OM_EXT:`KWD_OM_EN]
    : omr_q;
  assign cmr_d = cmr_wr ? avs_writedata_in[`KWD_CM_HP_HI:`KWD_CM_SEL_LO]
    : cmr_q;
  assign en = omr_q[`KWD_OM_EN];

  // ****************************************************
  // Prescaler
  // ****************************************************
  // Selected tick, restarted with the counter
  kwd_prescaler #(
    .DIV_W(`KWD_DIV1024_BITS)
  ) u_prescaler (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .clear_in(restart),
    .sel_in(kwd_clksel_t'(cmr_q[`KWD_CM_SEL_HI:`KWD_CM_SEL_LO])),
    .tick_out(tick)
  );

  // ****************************************************
  // Down counter and overflow
  // ****************************************************
  // Preload: high field over low ones
  assign preload = {cmr_q[`KWD_CM_HP_HI:`KWD_CM_HP_LO],
    `KWD_PRELOAD_LOW};
  assign ovf_evt = tick & en & (cnt_q == '0);
  assign cnt_d = restart ? preload
    : (tick & en) ? cnt_q - 1'b1
    : cnt_q;
  assign ovf_flag_d = ovf_evt | (ovf_flag_q & ~restart);

  // External pulse length counter
  assign ext_cnt_d = (ovf_evt & omr_q[`KWD_OM_EXT])
    ? PULSE_W'(`KWD_EXT_PULSE_CYC)
    : (ext_cnt_q != '0) ? ext_cnt_q - 1'b1 : ext_cnt_q;

  // ****************************************************
  // Interrupt status
  // ****************************************************
  // Set wins over a clear in the same cycle
  assign ev_vec = {key_fail, ovf_evt};
  assign clr_vec = (wr_acc & hit_icl) ? avs_writedata_in[1:0] : 2'b00;
  assign ist_d = ev_vec | (ist_q & ~clr_vec);
  assign ien_d = (wr_acc & hit_ien) ? avs_writedata_in[1:0] : ien_q;

  // ****************************************************
  // Bus answer
  // ****************************************************
  // One wait cycle, then one answer cycle
  assign bus_d = rd_acc ? KWD_BUS_ACK : KWD_BUS_WAIT;

  // Read mux; keys and reserved bits read zero
  assign rdata_d = !avs_read_in ? 32'h0000_0000
    : hit_omr ? {28'h000_0000, omr_q}
    : hit_cmr ? {26'h000_0000, cmr_q}
    : hit_ost ? {31'h0000_0000, ovf_flag_q}
    : hit_ist ? {30'h0000_0000, ist_q}
    : hit_ien ? {30'h0000_0000, ien_q}
    : 32'h0000_0000;

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = bus_q[0]; // Wait bit of the one-hot state
  assign internal_reset_request_out = rst_req_q;
  assign overflow_interrupt_pulse_out = int_pulse_q;
  assign overflow_output_n_out = ext_n_q;
  assign irq_out = irq_q;

  // ****************************************************
  // Registers
  // ****************************************************
  // Bus state and read data
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      bus_q <= KWD_BUS_WAIT;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      bus_q <= bus_d;
      rdata_q <= rd_acc ? rdata_d : rdata_q;
    end
  end

  // Mode registers, counter and flag
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      omr_q <= `KWD_OM_RESET;
      cmr_q <= `KWD_CM_RESET;
      cnt_q <= {4'h0, `KWD_PRELOAD_LOW};
      ovf_flag_q <= 1'b0;
    end
    else
    begin
      omr_q <= omr_d;
      cmr_q <= cmr_d;
      cnt_q <= cnt_d;
      ovf_flag_q <= ovf_flag_d;
    end
  end

  // Overflow outputs, gated by each enable
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rst_req_q <= 1'b0;
      int_pulse_q <= 1'b0;
      ext_cnt_q <= '0;
      ext_n_q <= 1'b1;
    end
    else
    begin
      rst_req_q <= ovf_evt & omr_q[`KWD_OM_RST];
      int_pulse_q <= ovf_evt & omr_q[`KWD_OM_IRQ];
      ext_cnt_q <= ext_cnt_d;
      ext_n_q <= (ext_cnt_d == '0);
    end
  end

  // Interrupt status, enable and line
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ist_q <= 2'b00;
      ien_q <= 2'b00;
      irq_q <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      ien_q <= ien_d;
      irq_q <= |(ist_d & ien_d);
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  // Reset request follows an enabled overflow
  property p_rst_req;
    @(posedge clk_sys_in) disable iff (srst_in)
    ovf_evt && omr_q[`KWD_OM_RST] |=> internal_reset_request_out;
  endproperty
  a_rst_req: assert property (p_rst_req)
    else $error("reset request missing after overflow");

  // Interrupt pulse is exactly one cycle
  property p_int_pulse;
    @(posedge clk_sys_in) disable iff (srst_in)
    ovf_evt && omr_q[`KWD_OM_IRQ] |=>
      overflow_interrupt_pulse_out ##1 !overflow_interrupt_pulse_out;
  endproperty
  a_int_pulse: assert property (p_int_pulse)
    else $error("interrupt pulse wrong");

  // Overflow pin low for exactly eight cycles
  property p_ext_pulse;
    @(posedge clk_sys_in) disable iff (srst_in)
    ovf_evt && omr_q[`KWD_OM_EXT] |=>
      !overflow_output_n_out [*8] ##1 overflow_output_n_out;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse)
    else $error("overflow pin pulse length wrong");

  // Counter counts down by one per tick
  property p_count_down;
    @(posedge clk_sys_in) disable iff (srst_in)
    tick && en && !restart |=> cnt_q == $past(cnt_q) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("counter did not decrement");

  // Restart loads the preload value
  property p_preload;
    @(posedge clk_sys_in) disable iff (srst_in)
    restart |=> cnt_q == {$past(cmr_q[`KWD_CM_HP_HI:`KWD_CM_HP_LO]),
      `KWD_PRELOAD_LOW};
  endproperty
  a_preload: assert property (p_preload)
    else $error("restart preload wrong");

  // Counter holds between ticks
  property p_tick_only;
    @(posedge clk_sys_in) disable iff (srst_in)
    !tick && !restart |=> $stable(cnt_q);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("counter moved without tick");

  // Wrong key leaves the overflow mode register
  property p_omr_key;
    @(posedge clk_sys_in) disable iff (srst_in)
    wr_acc && hit_omr
      && avs_writedata_in[`KWD_OM_KEY_HI:`KWD_OM_KEY_LO] != `KWD_OM_KEY
      |=> $stable(omr_q);
  endproperty
  a_omr_key: assert property (p_omr_key)
    else $error("overflow mode changed without key");

  // Wrong key leaves the clock mode register
  property p_cmr_key;
    @(posedge clk_sys_in) disable iff (srst_in)
    wr_acc && hit_cmr
      && avs_writedata_in[`KWD_CM_KEY_HI:`KWD_CM_KEY_LO] != `KWD_CM_KEY
      |=> $stable(cmr_q);
  endproperty
  a_cmr_key: assert property (p_cmr_key)
    else $error("clock mode changed without key");

  // Disabled timer produces no overflow outputs
  property p_disabled;
    @(posedge clk_sys_in) disable iff (srst_in)
    !en && ext_cnt_q == '0 |=> !internal_reset_request_out
      && !overflow_interrupt_pulse_out && overflow_output_n_out;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("output while disabled");

  // Overflow flag sets and restart clears it
  property p_flag;
    @(posedge clk_sys_in) disable iff (srst_in)
    (ovf_evt |=> ovf_flag_q) and (restart && !ovf_evt |=> !ovf_flag_q);
  endproperty
  a_flag: assert property (p_flag)
    else $error("overflow flag wrong");

endmodule // kwd_watchdog

/* dv/tb.sv */
// Purpose: Self-checking bench for the keyed watchdog timer
// Assumes: 100 MHz clock, Avalon-MM master driven on rising edges
// Notes:   Div8 overflow is timed; div32 must not match that time
`timescale 1ns/1ns
`include "kwd_cfg.svh"
module tb;
  import kwd_pkg::*;
  logic clk_sys_in;
  logic srst_in;
  logic [7:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_req;
  logic rst_req;
  logic irq_pulse;
  logic ovf_n;
  logic irq;
  logic [31:0] q;
  logic cnt_clr;
  int bad_count;
  int tests_run;
  int low_cnt;
  int rst_cnt;
  int pls_cnt;
  int waited;
  longint t0;
  longint cyc;

  // ****************************************************
  // Device and clock
  // ****************************************************
  kwd_watchdog i_dut
  (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .avs_address_in(addr),
    .avs_read_in(rd_en),
    .avs_write_in(wr_en),
    .avs_writedata_in(wdata),
    .avs_byteenable_in(be),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req),
    .internal_reset_request_out(rst_req),
    .overflow_interrupt_pulse_out(irq_pulse),
    .overflow_output_n_out(ovf_n),
    .irq_out(irq)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Cycle counts of the overflow outputs
  always @(posedge clk_sys_in)
  begin
    if (cnt_clr)
    begin
      low_cnt = 0;
      rst_cnt = 0;
      pls_cnt = 0;
    end
    else
    begin
      if (ovf_n === 1'b0) low_cnt++;
      if (rst_req === 1'b1) rst_cnt++;
      if (irq_pulse === 1'b1) pls_cnt++;
    end
  end

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic test_done();
    $display("Checks run %0d, errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] lanes);
    int n;
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    be <= lanes;
    wr_en <= wr;
    rd_en <= !wr;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (wait_req !== 1'b0 && n < 20);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (wait_req !== 1'b0)
    begin
      bad_count++;
      $display("ERROR waitrequest expected 0 seen %b", wait_req);
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input string name, input logic [7:0] a,
    input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(name, exp, q);
  endtask

  // Bounded wait for the overflow pin to go low
  task automatic wait_ovf(input int lim);
    waited = 0;
    while (ovf_n !== 1'b0 && waited < lim)
    begin
      @(posedge clk_sys_in);
      waited++;
    end
    if (ovf_n !== 1'b0)
    begin
      bad_count++;
      $display("ERROR ovf_n wait expected 0 seen %b", ovf_n);
      test_done();
    end
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    srst_in = 1'b1;
    addr = 8'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    cnt_clr = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    chk("ovf_n idle", 32'h1, {31'h0, ovf_n});
    rd("overflow_mode", `KWD_OFS_OVF_MODE, 32'h0);
    rd("clock_mode", `KWD_OFS_CLK_MODE, 32'h0);
    rd("overflow_status", `KWD_OFS_OVF_STAT, 32'h0);
    rd("unmapped", 8'h1C, 32'h0);
    wr(`KWD_OFS_IRQ_EN, 32'h3);
    rd("irq_enable", `KWD_OFS_IRQ_EN, 32'h3);
    // Bad key, then good key on too few lanes
    wr(`KWD_OFS_OVF_MODE, 32'h2355);
    bus(1'b1, `KWD_OFS_OVF_MODE, 32'h2345, 4'h1);
    rd("overflow_mode", `KWD_OFS_OVF_MODE, 32'h0);
    rd("irq_status", `KWD_OFS_IRQ_STAT, 32'h2);
    chk("irq_out", 32'h1, {31'h0, irq});
    wr(`KWD_OFS_IRQ_EN, 32'h1);
    rd("irq_enable", `KWD_OFS_IRQ_EN, 32'h1);
    chk("irq_out masked", 32'h0, {31'h0, irq});
    wr(`KWD_OFS_IRQ_CLR, 32'h2);
    rd("irq_status", `KWD_OFS_IRQ_STAT, 32'h0);
    wr(`KWD_OFS_IRQ_EN, 32'h3);
    wr(`KWD_OFS_CLK_MODE, 32'h3F0D);
    rd("clock_mode", `KWD_OFS_CLK_MODE, 32'h0);
    wr(`KWD_OFS_IRQ_CLR, 32'h3);
    // Enabling sequence with div8 and zero high preload
    wr(`KWD_OFS_OVF_MODE, 32'h2340);
    wr(`KWD_OFS_CLK_MODE, 32'h3700);
    wr(`KWD_OFS_RESTART, 32'hC071);
    t0 = $time;
    wr(`KWD_OFS_OVF_MODE, 32'h234F);
    rd("overflow_mode", `KWD_OFS_OVF_MODE, 32'hF);
    cnt_clr <= 1'b1;
    @(posedge clk_sys_in);
    cnt_clr <= 1'b0;
    repeat (16000) @(posedge clk_sys_in);
    chk("no early overflow", 32'h0, low_cnt);
    wr(`KWD_OFS_RESTART, 32'hC070);
    wait_ovf(20000);
    cyc = ($time - t0) / 10;
    chk("overflow time ok", 32'h1,
      {31'h0, cyc >= 32760 && cyc <= 32800});
    repeat (20) @(posedge clk_sys_in);
    chk("ovf_n low cycles", 32'h8, low_cnt);
    chk("reset request pulses", 32'h1, rst_cnt);
    chk("interrupt pulses", 32'h1, pls_cnt);
    chk("irq_out overflow", 32'h1, {31'h0, irq});
    rd("overflow_status", `KWD_OFS_OVF_STAT, 32'h1);
    // Overflow plus the refused restart key
    rd("irq_status", `KWD_OFS_IRQ_STAT, 32'h3);
    wr(`KWD_OFS_RESTART, 32'hC071);
    rd("overflow_status", `KWD_OFS_OVF_STAT, 32'h0);
    wr(`KWD_OFS_IRQ_CLR, 32'h3);
    rd("irq_status", `KWD_OFS_IRQ_STAT, 32'h0);
    chk("irq_out cleared", 32'h0, {31'h0, irq});
    // Div32 must not overflow within the div8 time
    wr(`KWD_OFS_CLK_MODE, 32'h3701);
    rd("clock_mode", `KWD_OFS_CLK_MODE, 32'h1);
    wr(`KWD_OFS_RESTART, 32'hC071);
    cnt_clr <= 1'b1;
    @(posedge clk_sys_in);
    cnt_clr <= 1'b0;
    repeat (33500) @(posedge clk_sys_in);
    chk("div32 no overflow", 32'h0, low_cnt);
    test_done();
  end
endmodule // tb
